//--- inc/dma_evt_pkg.sv
// constants and carrier types for the dma channel event/interrupt block
// assumes a 32-bit register port with one-cycle read latency
package dma_evt_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_ECON = 4'h0;
  localparam logic [3:0] OFF_INT = 4'h4;
  localparam logic [3:0] OFF_SSA = 4'h8;
  localparam logic [3:0] OFF_DSA = 4'hc;
  localparam logic [3:0] OFF_CTRL = 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CHCTL = 4'h0;
  // event control field positions
  localparam int AIRQ_LSB = 16;
  localparam int SIRQ_LSB = 8;
  localparam int FORCE_BIT = 7;
  localparam int ABORT_BIT = 6;
  localparam int PAT_BIT = 5;
  localparam int SIEN_BIT = 4;
  localparam int AIEN_BIT = 3;
  localparam logic [7:0] IRQ_SEL_RST = 8'hff;
  // interrupt control layout
  localparam int IE_LSB = 16;
  localparam int FLAG_LSB = 0;
  localparam int F_SDONE = 7;
  localparam int F_SHALF = 6;
  localparam int F_DDONE = 5;
  localparam int F_DHALF = 4;
  localparam int F_BLOCK = 3;
  localparam int F_CELL = 2;
  localparam int F_ABORT = 1;
  localparam int F_AERR = 0;
  // channel control register (own offset)
  localparam logic [3:0] OFF_CHAN = 4'h1;
  localparam int CH_ON_BIT = 7;
  localparam int CH_AED_BIT = 6;
  localparam int CH_AEN_BIT = 4;
  localparam int CH_BUSY_BIT = 15;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] src_ptr;
    logic [15:0] src_size;
    logic [15:0] dst_ptr;
    logic [15:0] dst_size;
    logic cell_done;
    logic block_done;
    logic pattern_match;
    logic addr_error;
  } xfer_stat_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_BUSY = 3'b100
  } chan_state_t;
endpackage

//--- core/dma_evt_ctrl.sv
// dma channel event and interrupt control: selectors, flags, start addresses
// assumes the transfer engine reports progress on the xfer status inputs
// in sys_clk domain; irq_event is a one-cycle strobe with irq_num from the
// system interrupt controller on the same clock.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module dma_evt_ctrl
  import dma_evt_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire reg_req_t req,
  output logic [31:0] rdata,
  // system interrupt events
  input wire logic irq_event,
  input wire logic [7:0] irq_num,
  // transfer engine status
  input wire xfer_stat_t xstat,
  // transfer engine control
  output logic start_xfer,
  output logic abort_xfer,
  output logic busy,
  output logic chan_irq
);

  logic [7:0] abort_sel_r;
  logic [7:0] start_sel_r;
  logic pat_en_r, sien_r, aien_r;
  logic [7:0] ie_r, flag_r, flag_nxt;
  logic [31:0] ssa_r, dsa_r;
  logic ch_on_r, aed_r, aen_r, ch_on_nxt;
  logic [31:0] rdata_nxt;
  logic start_r, abort_r, irq_r, busy_r;
  logic [3:0] mark_hit_r;
  chan_state_t st_r, st_nxt;

  function automatic logic at_half(input logic [15:0] p, input logic [15:0] s);
    // a size of zero means 65536 bytes, half of that is 32768
    at_half = (p == ((s == 16'h0000) ? 16'h8000 : {1'b0, s[15:1]}));
  endfunction

  // register decode
  wire wr_econ = req.wr && req.addr == OFF_ECON;
  wire wr_int = req.wr && req.addr == OFF_INT;
  wire wr_ssa = req.wr && req.addr == OFF_SSA;
  wire wr_dsa = req.wr && req.addr == OFF_DSA;
  wire wr_chan = req.wr && req.addr == OFF_CHAN;
  // write data fields watched by the checks below
  wire [7:0] wdata_ie = req.wdata[IE_LSB +: 8];
  wire [7:0] wdata_asel = req.wdata[AIRQ_LSB +: 8];

  // events are admitted while on, or while off if allowed
  wire ev_ok = ch_on_r || aed_r;
  wire irq_start = irq_event && sien_r && irq_num == start_sel_r;
  wire irq_abort = irq_event && aien_r && irq_num == abort_sel_r;
  wire sw_force = wr_econ && req.wdata[FORCE_BIT];
  wire sw_abort = wr_econ && req.wdata[ABORT_BIT];
  wire pat_abort = pat_en_r && xstat.pattern_match;
  wire irq_abort_ok = irq_abort && ev_ok;
  wire do_abort = irq_abort_ok || sw_abort || pat_abort;
  wire do_start = ((irq_start && ev_ok) || sw_force) && !do_abort;
  wire blk_end = xstat.block_done || (pat_en_r && xstat.pattern_match);

  // pointer marks are edge detected: a pointer parked on its mark sets the
  // flag once, so software can clear it; reset value all ones hides the
  // all-zero status that the engine shows straight after reset
  wire src_done_hit = xstat.src_ptr == xstat.src_size;
  wire src_half_hit = at_half(xstat.src_ptr, xstat.src_size);
  wire dst_done_hit = xstat.dst_ptr == xstat.dst_size;
  wire dst_half_hit = at_half(xstat.dst_ptr, xstat.dst_size);
  wire [3:0] mark_hit = {src_done_hit, src_half_hit, dst_done_hit, dst_half_hit};
  wire [3:0] mark_rise = mark_hit & ~mark_hit_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mark_hit_r <= 4'hf;
    end else begin
      mark_hit_r <= mark_hit;
    end
  end

  // status events
  wire [7:0] ev_set = {
    mark_rise[3],
    mark_rise[2],
    mark_rise[1],
    mark_rise[0],
    xstat.block_done || xstat.pattern_match,
    xstat.cell_done,
    irq_abort_ok,
    xstat.addr_error
  };

  // hardware set wins over a software write in the same cycle
  always_comb begin
    flag_nxt = flag_r;
    if (wr_int) begin
      flag_nxt = req.wdata[FLAG_LSB +: 8];
    end
    flag_nxt = flag_nxt | ev_set;
  end

  always_comb begin
    ch_on_nxt = ch_on_r;
    if (wr_chan) begin
      ch_on_nxt = req.wdata[CH_ON_BIT];
    end
    if (pat_abort) begin
      ch_on_nxt = 1'b0;
    end else if (xstat.block_done && !aen_r) begin
      ch_on_nxt = 1'b0;
    end
  end

  always_comb begin
    case (st_r)
      ST_IDLE: st_nxt = ch_on_r ? ST_ARMED : ST_IDLE;
      ST_ARMED: st_nxt = do_abort ? ST_ARMED : (do_start ? ST_BUSY : ST_ARMED);
      ST_BUSY: st_nxt = (do_abort || blk_end) ? ST_ARMED : ST_BUSY;
      default: st_nxt = ST_IDLE;
    endcase
    if (!ch_on_nxt && st_nxt == ST_ARMED) begin
      st_nxt = ST_IDLE;
    end
    if (do_start && st_r != ST_BUSY) begin
      st_nxt = ST_BUSY;
    end
  end

  // read mux, unimplemented bits zero
  always_comb begin
    case (req.addr)
      OFF_ECON: rdata_nxt = {8'h00, abort_sel_r, start_sel_r, 2'b00, pat_en_r,
                             sien_r, aien_r, 3'b000};
      OFF_INT: rdata_nxt = {8'h00, ie_r, 8'h00, flag_r};
      OFF_SSA: rdata_nxt = ssa_r;
      OFF_DSA: rdata_nxt = dsa_r;
      OFF_CHAN: rdata_nxt = {16'h0000, st_r == ST_BUSY, 7'h00, ch_on_r, aed_r,
                             1'b0, aen_r, 4'h0};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      abort_sel_r <= IRQ_SEL_RST;
      start_sel_r <= IRQ_SEL_RST;
      pat_en_r <= 1'b0;
      sien_r <= 1'b0;
      aien_r <= 1'b0;
    end else if (wr_econ) begin
      abort_sel_r <= req.wdata[AIRQ_LSB +: 8];
      start_sel_r <= req.wdata[SIRQ_LSB +: 8];
      pat_en_r <= req.wdata[PAT_BIT];
      sien_r <= req.wdata[SIEN_BIT];
      aien_r <= req.wdata[AIEN_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ie_r <= 8'h00;
      flag_r <= 8'h00;
    end else begin
      if (wr_int) begin
        ie_r <= req.wdata[IE_LSB +: 8];
      end
      flag_r <= flag_nxt;
    end
  end

  // software owns these; physical addresses assumed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ssa_r <= 32'h0000_0000;
      dsa_r <= 32'h0000_0000;
    end else begin
      if (wr_ssa) begin
        ssa_r <= req.wdata;
      end
      if (wr_dsa) begin
        dsa_r <= req.wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ch_on_r <= 1'b0;
      aed_r <= 1'b0;
      aen_r <= 1'b0;
      st_r <= ST_IDLE;
    end else begin
      ch_on_r <= ch_on_nxt;
      if (wr_chan) begin
        aed_r <= req.wdata[CH_AED_BIT];
        aen_r <= req.wdata[CH_AEN_BIT];
      end
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
      start_r <= 1'b0;
      abort_r <= 1'b0;
      irq_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      rdata <= req.rd ? rdata_nxt : 32'h0000_0000;
      busy_r <= st_nxt == ST_BUSY;
      start_r <= do_start;
      abort_r <= do_abort;
      irq_r <= |(flag_nxt & (wr_int ? req.wdata[IE_LSB +: 8] : ie_r));
    end
  end

  assign start_xfer = start_r;
  assign abort_xfer = abort_r;
  assign chan_irq = irq_r;
  assign busy = busy_r;

  // checks
  abort_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_event && aien_r && irq_num == abort_sel_r && ch_on_r |=> abort_xfer && flag_r[F_ABORT])
    else $error("abort irq did not abort");
  start_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_event && !sien_r && !req.wr |=> !start_xfer)
    else $error("start irq not gated");
  force_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sw_force && !do_abort |=> start_xfer ##1 busy)
    else $error("force did not start");
  sw_abort_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sw_abort |=> abort_xfer)
    else $error("abort bit ignored");
  pat_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pat_en_r && xstat.pattern_match |=> !ch_on_r)
    else $error("pattern abort kept channel on");
  cell_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    xstat.cell_done |=> flag_r[F_CELL])
    else $error("cell flag not set");
  aerr_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    xstat.addr_error |=> flag_r[F_AERR])
    else $error("address error flag not set");
  off_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ch_on_r && !aed_r && !req.wr && !pat_abort |=> !abort_xfer && !start_xfer)
    else $error("event taken while off");
  auto_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    xstat.block_done && !aen_r |=> !ch_on_r)
    else $error("channel stayed on after block");
  irq_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 chan_irq == |($past(flag_nxt) & ie_r))
    else $error("irq mismatch");
  unimpl_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req.rd && req.addr == OFF_INT |=> rdata[15:8] == 8'h00 && rdata[31:24] == 8'h00)
    else $error("reserved bits not zero");
  // event gating
  start_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_start && ev_ok && !do_abort
    |=> start_xfer)
    else $error("selected start irq ignored");
  abort_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_event && !aien_r && !sw_abort && !pat_abort
    |=> !abort_xfer)
    else $error("abort irq not gated");
  events_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_start && aed_r && !ch_on_r && !do_abort
    |=> start_xfer)
    else $error("allowed event while off ignored");
  auto_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ch_on_r && xstat.block_done && aen_r && !pat_abort && !wr_chan
    |=> ch_on_r)
    else $error("auto enable channel turned off");
  // register contents
  force_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req.rd && req.addr == OFF_ECON
    |=> !rdata[FORCE_BIT])
    else $error("force bit read as one");
  abort_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req.rd && req.addr == OFF_ECON
    |=> !rdata[ABORT_BIT])
    else $error("abort bit read as one");
  sel_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_econ
    |=> abort_sel_r == $past(wdata_asel))
    else $error("abort selector not written");
  ie_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_int
    |=> ie_r == $past(wdata_ie))
    else $error("interrupt enables not written");
  ssa_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_ssa
    |=> ssa_r == $past(req.wdata))
    else $error("source address not written");
  dsa_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_dsa
    |=> dsa_r == $past(req.wdata))
    else $error("destination address not written");
  econ_resv_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req.rd && req.addr == OFF_ECON
    |=> rdata[31:24] == 8'h00 && rdata[2:0] == 3'b000)
    else $error("event control reserved bits not zero");
  rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !req.rd
    |=> rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  // status flags
  src_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mark_rise[3]
    |=> flag_r[F_SDONE])
    else $error("source done flag not set");
  src_half_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mark_rise[2]
    |=> flag_r[F_SHALF])
    else $error("source half flag not set");
  dst_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mark_rise[1]
    |=> flag_r[F_DDONE])
    else $error("dest done flag not set");
  dst_half_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mark_rise[0]
    |=> flag_r[F_DHALF])
    else $error("dest half flag not set");
  block_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    xstat.block_done || xstat.pattern_match
    |=> flag_r[F_BLOCK])
    else $error("block flag not set");
  abort_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_abort_ok
    |=> flag_r[F_ABORT])
    else $error("abort flag not set");
  // interrupt request
  irq_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ie_r == 8'h00 && !wr_int
    |=> !chan_irq)
    else $error("irq without enable");
  irq_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (|(flag_r & ie_r)) && !wr_int
    |=> chan_irq)
    else $error("enabled flag raised no irq");
  one_state_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $onehot(st_r))
    else $error("state not one-hot");
  cov_start_c: cover property (@(posedge sys_clk) disable iff (!rst_n) irq_start ##1 start_xfer);
  cov_block_c: cover property (@(posedge sys_clk) disable iff (!rst_n) busy ##1 !busy);
  cov_pat_c: cover property (@(posedge sys_clk) disable iff (!rst_n) pat_abort ##1 abort_xfer);
  cov_abort_c: cover property (@(posedge sys_clk) disable iff (!rst_n) busy ##1 abort_xfer);
  cov_irq_c: cover property (@(posedge sys_clk) disable iff (!rst_n) !chan_irq ##1 chan_irq);
endmodule

//--- verif/xfer_engine_model.sv
// behavioural transfer engine on the far side of the channel block
// assumes start_xfer and abort_xfer are one-cycle pulses on sys_clk
`timescale 1ns/100ps
module xfer_engine_model
  import dma_evt_pkg::*;
#(
  parameter int SIZE = 8
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // channel side
  input wire logic start_xfer,
  input wire logic abort_xfer,
  output xfer_stat_t xstat,
  // bench controls
  input wire logic slow,
  input wire logic bad_addr,
  input wire logic pat
);
  logic [2:0] wait_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xstat <= '0;
      wait_r <= 3'h0;
    end else begin
      xstat.src_size <= SIZE[15:0];
      xstat.dst_size <= SIZE[15:0];
      xstat.cell_done <= 1'b0;
      xstat.block_done <= 1'b0;
      xstat.addr_error <= 1'b0;
      xstat.pattern_match <= pat;
      // wrap after one cycle at the end so done flags see a single match
      if (xstat.src_ptr == SIZE[15:0]) begin
        xstat.src_ptr <= 16'h0;
        xstat.dst_ptr <= 16'h0;
        xstat.block_done <= 1'b1;
      end
      if (abort_xfer) begin
        xstat.src_ptr <= 16'h0;
        xstat.dst_ptr <= 16'h0;
        wait_r <= 3'h0;
      end else if (start_xfer) begin
        wait_r <= slow ? 3'h4 : 3'h1;
      end else if (wait_r == 3'h1) begin
        xstat.src_ptr <= xstat.src_ptr + SIZE[16:1];
        xstat.dst_ptr <= xstat.dst_ptr + SIZE[16:1];
        xstat.cell_done <= 1'b1;
        xstat.addr_error <= bad_addr;
        wait_r <= 3'h0;
      end else if (wait_r != 3'h0) begin
        wait_r <= wait_r - 3'h1;
      end
    end
  end
endmodule

//--- verif/dma_evt_ctrl_tb_top.sv
// self-checking bench for the channel event/interrupt block
// assumes the behavioural engine model with size 8 on the far side
`timescale 1ns/100ps
module dma_evt_ctrl_tb_top;
  import dma_evt_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t req = '0;
  logic [31:0] rdata;
  logic irq_event = 1'b0;
  logic [7:0] irq_num = 8'h00;
  xfer_stat_t xstat;
  logic start_xfer, abort_xfer, busy, chan_irq;
  logic slow = 1'b0;
  logic bad_addr = 1'b0;
  logic pat = 1'b0;
  int bad_count = 0;
  int compares = 0;
  int n_start = 0;
  int n_abort = 0;
  int seed = 59574;
  logic [31:0] v;
  logic [7:0] s, a;
  always #5 sys_clk = ~sys_clk;
  // count on the falling edge, away from the launching edge
  always @(negedge sys_clk) begin
    if (start_xfer === 1'b1) n_start++;
    if (abort_xfer === 1'b1) n_abort++;
  end
  dma_evt_ctrl dma_evt_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .req(req),
    .rdata(rdata), .irq_event(irq_event), .irq_num(irq_num), .xstat(xstat),
    .start_xfer(start_xfer), .abort_xfer(abort_xfer), .busy(busy), .chan_irq(chan_irq));
  xfer_engine_model xfer_engine_model_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .start_xfer(start_xfer), .abort_xfer(abort_xfer), .xstat(xstat), .slow(slow),
    .bad_addr(bad_addr), .pat(pat));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] ad, output logic [31:0] d);
    @(posedge sys_clk);
    req <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(input string what, input logic [3:0] ad, input logic [31:0] exp);
    rd(ad, v);
    check(what, v, exp);
  endtask
  // bounded poll: a slow engine may take several reads to settle
  task automatic poll(input string what, input logic [31:0] exp);
    for (int i = 0; i < 20; i++) begin
      rd(OFF_INT, v);
      if (v === exp) break;
    end
    check(what, v, exp);
  endtask
  task automatic irq(input logic [7:0] n);
    @(posedge sys_clk);
    irq_event <= 1'b1;
    irq_num <= n;
    @(posedge sys_clk);
    irq_event <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk("econ_rst", OFF_ECON, 32'h00ffff00);
    rchk("int_rst", OFF_INT, 32'h0);
    rchk("ssa_rst", OFF_SSA, 32'h0);
    rchk("dsa_rst", OFF_DSA, 32'h0);
    rchk("hole", 4'h2, 32'h0);
    rchk("chan_rst", OFF_CHAN, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(OFF_DSA, v);
      rchk("dsa_rw", OFF_DSA, v);
      v = ($random(seed) & 32'hffffff00) | 32'h000000d0;
      wr(OFF_SSA, v);
      rchk("ssa_rw", OFF_SSA, v);
      v = $random(seed);
      wr(OFF_INT, v);
      rchk("int_rw", OFF_INT, v & 32'h00ff00ff);
      v = $random(seed) & 32'hffffff3f;
      wr(OFF_ECON, v);
      rchk("econ_rw", OFF_ECON, v & 32'h00ffff38);
    end
    s = $random(seed);
    a = s ^ 8'h5a;
    n_start = 0;
    wr(OFF_CHAN, 32'h00000080);
    wr(OFF_ECON, {8'h0, 8'h00, s, 8'h10});
    irq(s + 8'h1);
    check("start_other", n_start, 0);
    irq(s);
    check("start_sel", n_start, 1);
    wr(OFF_ECON, {8'h0, 8'h00, s, 8'h00});
    irq(s);
    check("start_gated", n_start, 1);
    wr(OFF_INT, 32'h0);
    wr(OFF_ECON, {8'h0, a, s, 8'h08});
    irq(a);
    check("abort_sel", n_abort, 1);
    rd(OFF_INT, v);
    check("abort_flag", {31'h0, v[F_ABORT]}, 32'h1);
    wr(OFF_ECON, {8'h0, a, s, 8'h00});
    irq(a);
    check("abort_gated", n_abort, 1);
    wr(OFF_ECON, 32'h00000040);
    check("abort_bit", n_abort, 2);
    wr(OFF_INT, 32'h0);
    slow <= 1'b1;
    wr(OFF_ECON, 32'h00000080);
    check("force_bit", n_start, 2);
    rchk("force_rd0", OFF_ECON, 32'h0);
    poll("half_cell", 32'h00000054);
    wr(OFF_ECON, 32'h00000080);
    poll("done_block", 32'h000000fc);
    rchk("auto_off", OFF_CHAN, 32'h0);
    wr(OFF_INT, 32'h00080008);
    check("irq_on", {31'h0, chan_irq}, 32'h1);
    wr(OFF_INT, 32'h00070008);
    check("irq_off", {31'h0, chan_irq}, 32'h0);
    wr(OFF_INT, 32'h0);
    slow <= 1'b0;
    bad_addr <= 1'b1;
    wr(OFF_ECON, 32'h00000080);
    poll("addr_err", 32'h00000055);
    bad_addr <= 1'b0;
    wr(OFF_ECON, 32'h00000040);
    wr(OFF_INT, 32'h0);
    n_abort = 0;
    wr(OFF_CHAN, 32'h00000080);
    wr(OFF_ECON, 32'h00000020);
    @(posedge sys_clk);
    pat <= 1'b1;
    @(posedge sys_clk);
    pat <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check("pat_abort", n_abort, 1);
    poll("pat_block", 32'h00000008);
    rchk("pat_channel_on", OFF_CHAN, 32'h0);
    wr(OFF_ECON, 32'h0);
    @(posedge sys_clk);
    pat <= 1'b1;
    @(posedge sys_clk);
    pat <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check("pat_off", n_abort, 1);
    wr(OFF_SSA, 32'h0);
    wr(OFF_ECON, {8'h0, 8'h00, s, 8'h10});
    n_start = 0;
    irq(s);
    check("off_ignored", n_start, 0);
    wr(OFF_CHAN, 32'h00000040);
    irq(s);
    check("off_allowed", n_start, 1);
    wr(OFF_CHAN, 32'h00000090);
    wr(OFF_ECON, 32'h00000080);
    rchk("auto_keep", OFF_CHAN, 32'h00000090);
    final_report();
  end
endmodule
